/* File: pwm_autoreload_timer.sv */
// AHB-Lite PWM auto-reload timer with four PWM outputs and two input captures
//
// The AHB-Lite interface to the registers is this design's own decision.
`include "pwm_reload_cfg.svh"
`timescale 1ns/1ps

module pwm_autoreload_timer
	import pwm_reload_pkg::*;
(
	input wire logic hclk, // Bus and CPU clock, 40 MHz
	input wire logic hresetn, // Asynchronous reset, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size
	input wire logic hready, // Bus ready in
	input wire logic [31:0] hwdata, // Write data
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	input wire logic ext_clk_in, // External count source, synchronous
	input wire logic [1:0] capture_input_pin, // Capture inputs
	output logic [3:0] pwm_channel_out, // PWM pin levels
	output logic [3:0] pwm_pin_oe_n, // Pin driven when low
	output logic overflow_irq, // Overflow interrupt request
	output logic [1:0] capture_irq // Capture interrupt requests
);

	// ************************************************************
	// Bus slave
	// ************************************************************
	bus_state_e bus_st_r;
	bus_req_s req_r;
	logic [7:0] duty_r [4];
	pwm_ctl_s pwmctl_r;
	logic [7:0] tcs_r;
	logic [7:0] cnt_r;
	logic [7:0] reload_r;
	cap_ctl_s capctl_r;
	logic [1:0] capflag_r;
	logic [7:0] capdata_r [2];
	logic [`PRE_WIDTH-1:0] pre_r;
	logic [7:0] cmp_r [4];
	logic ext_d_r;
	logic [1:0] cap_d_r;
	logic [3:0] raw_r;
	logic [7:0] rdata_nxt;
	logic [7:0] cnt_nxt;

	wire addr_ok = haddr[1:0] == 2'b00 && haddr[31:10] == 22'h0;
	wire take = hsel && hready && htrans[1];
	wire wr_now = req_r.write;
	wire [7:0] wd = hwdata[7:0];
	wire rd_tcs = req_r.read && req_r.index == `IDX_TCS;
	wire [1:0] rd_cap = {req_r.read && req_r.index == `IDX_CAP2, req_r.read && req_r.index == `IDX_CAP1};

	function automatic logic wr_hit(input bus_req_s r, input logic [7:0] idx);
		wr_hit = r.write && r.index == idx;
	endfunction : wr_hit

	// Active edge judged against last cycle's level, so a level held since reset never captures
	function automatic logic cap_event(input logic pin, input logic prev, input logic rising);
		cap_event = pin != prev && pin == rising;
	endfunction : cap_event

	// Zero-wait slave: address phase taken, data phase always ready
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_st_r <= BUS_IDLE;
			req_r <= '0;
		end else begin
			bus_st_r <= take ? BUS_DATA : BUS_IDLE;
			req_r.index <= haddr[9:2];
			req_r.write <= take && hwrite && addr_ok;
			req_r.read <= take && !hwrite && addr_ok;
		end
	end

	always_comb begin
		rdata_nxt = 8'h00;
		unique case (req_r.index)
			`IDX_DUTY3: rdata_nxt = duty_r[3];
			`IDX_DUTY2: rdata_nxt = duty_r[2];
			`IDX_DUTY1: rdata_nxt = duty_r[1];
			`IDX_DUTY0: rdata_nxt = duty_r[0];
			`IDX_PWMCTL: rdata_nxt = pwmctl_r;
			`IDX_TCS: rdata_nxt = tcs_r & ~(8'h01 << `TCS_FRL_BIT);
			`IDX_CNT: rdata_nxt = cnt_r;
			`IDX_RELOAD: rdata_nxt = reload_r;
			`IDX_CCS: rdata_nxt = {2'b00, capctl_r, capflag_r};
			`IDX_CAP1: rdata_nxt = capdata_r[0];
			`IDX_CAP2: rdata_nxt = capdata_r[1];
			default: rdata_nxt = 8'h00;
		endcase
	end

	// Read data is combinational in the data phase, so hrdata is not registered
	always_comb begin
		hrdata = {24'h0, (req_r.read && bus_st_r == BUS_DATA) ? rdata_nxt : 8'h00};
		hreadyout = 1'b1;
		hresp = 1'b0;
	end

	// ************************************************************
	// Control registers
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 4; i++) begin
				duty_r[i] <= `REG_RESET;
			end
			pwmctl_r <= `REG_RESET;
			reload_r <= `REG_RESET;
			capctl_r <= '0;
		end else begin
			if (wr_hit(req_r, `IDX_DUTY0)) duty_r[0] <= wd;
			if (wr_hit(req_r, `IDX_DUTY1)) duty_r[1] <= wd;
			if (wr_hit(req_r, `IDX_DUTY2)) duty_r[2] <= wd;
			if (wr_hit(req_r, `IDX_DUTY3)) duty_r[3] <= wd;
			if (wr_hit(req_r, `IDX_PWMCTL)) pwmctl_r <= wd;
			if (wr_hit(req_r, `IDX_RELOAD)) reload_r <= wd;
			if (wr_hit(req_r, `IDX_CCS)) capctl_r <= wd[5:2];
		end
	end

	// ************************************************************
	// Prescaler and counter
	// ************************************************************
	wire run = tcs_r[`TCS_RUN_BIT];
	wire [2:0] psel = tcs_r[`TCS_PRE_HI:`TCS_PRE_LO];
	wire ext_edge = ext_clk_in && !ext_d_r;
	wire in_tick = tcs_r[`TCS_EXT_BIT] ? ext_edge : 1'b1;
	// Tick when the low prescaler bits are all ones; the divider stays a plain binary count
	wire [`PRE_WIDTH-1:0] pre_mask = `PRE_WIDTH'((8'h01 << psel) - 8'h01);
	wire cnt_tick = run && in_tick && ((pre_r & pre_mask) == pre_mask);
	wire ovf = cnt_tick && cnt_r == `CNT_TOP;
	wire force_rl = wr_hit(req_r, `IDX_TCS) && wd[`TCS_FRL_BIT];
	wire cnt_wr = wr_hit(req_r, `IDX_CNT);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_d_r <= 1'b0;
		end else begin
			ext_d_r <= ext_clk_in;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_r <= '0;
		end else if (force_rl || cnt_wr) begin
			pre_r <= '0;
		end else if (run && in_tick) begin
			pre_r <= pre_r + 1'b1;
		end
	end

	// A software write wins over the tick; the count restarts from the written value
	always_comb begin
		cnt_nxt = cnt_r;
		if (cnt_wr) begin
			cnt_nxt = wd;
		end else if (force_rl) begin
			cnt_nxt = reload_r;
		end else if (ovf) begin
			cnt_nxt = reload_r;
		end else if (cnt_tick) begin
			cnt_nxt = cnt_r + 8'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= `REG_RESET;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// Overflow flag: set wins over the clearing read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tcs_r <= `REG_RESET;
		end else begin
			if (wr_hit(req_r, `IDX_TCS)) begin
				tcs_r[7:1] <= {wd[7:3], 1'b0, wd[1]};
			end
			if (ovf) begin
				tcs_r[`TCS_OVF_BIT] <= 1'b1;
			end else if (rd_tcs) begin
				tcs_r[`TCS_OVF_BIT] <= 1'b0;
			end
		end
	end

	// ************************************************************
	// PWM compare and outputs
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 4; i++) begin
				cmp_r[i] <= `REG_RESET;
			end
		end else if (ovf) begin
			for (int i = 0; i < 4; i++) begin
				cmp_r[i] <= duty_r[i];
			end
		end
	end

	// Raw level from the next counter value, so the wrap and output change coincide
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			raw_r <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (ovf) begin
					raw_r[i] <= 1'b1;
				end else begin
					raw_r[i] <= cnt_nxt <= cmp_r[i];
				end
			end
		end
	end

	// Polarity applied after the raw level keeps its effect immediate
	always_comb begin
		pwm_channel_out = raw_r ^ pwmctl_r.polarity;
		pwm_pin_oe_n = ~pwmctl_r.out_en;
	end

	// ************************************************************
	// Input capture
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_d_r <= 2'b00;
			capflag_r <= 2'b00;
			capdata_r[0] <= `REG_RESET;
			capdata_r[1] <= `REG_RESET;
		end else begin
			cap_d_r <= capture_input_pin;
			for (int i = 0; i < 2; i++) begin
				// Data is held while a flag is pending so it is not overwritten
				if (cap_event(capture_input_pin[i], cap_d_r[i], capctl_r.sense[i]) && !capflag_r[i]) begin
					capflag_r[i] <= 1'b1;
					capdata_r[i] <= cnt_r;
				end else if (rd_cap[i]) begin
					capflag_r[i] <= 1'b0;
				end
			end
		end
	end

	always_comb begin
		overflow_irq = tcs_r[`TCS_OIE_BIT] && tcs_r[`TCS_OVF_BIT];
		capture_irq = capctl_r.irq_en & capflag_r;
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_ovf_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		overflow_irq == (tcs_r[1] && tcs_r[0])) else $error("overflow irq mismatch");
	a_ovf_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		ovf |=> tcs_r[0]) else $error("overflow flag not set");
	a_ovf_reload_cnt: assert property (@(posedge hclk) disable iff (!hresetn)
		ovf && !cnt_wr && !force_rl |=> cnt_r == $past(reload_r)) else $error("reload missed");
	a_force_reload_pre: assert property (@(posedge hclk) disable iff (!hresetn)
		force_rl && !cnt_wr |=> pre_r == 0 && cnt_r == $past(reload_r)) else $error("force reload failed");
	a_stop_freezes: assert property (@(posedge hclk) disable iff (!hresetn)
		!run && !cnt_wr && !force_rl |=> $stable(cnt_r) && $stable(pre_r)) else $error("counter moved while stopped");
	a_cmp_only_ovf: assert property (@(posedge hclk) disable iff (!hresetn)
		!ovf |=> $stable(cmp_r[0])) else $error("compare changed off overflow");
	a_ccs_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
		req_r.read && req_r.index == `IDX_CCS |-> hrdata[7:6] == 2'b00) else $error("reserved bits set");
	a_cap_data_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		capflag_r[0] |=> $stable(capdata_r[0])) else $error("capture data overwritten");
	a_cnt_write_load: assert property (@(posedge hclk) disable iff (!hresetn)
		cnt_wr |=> cnt_r == $past(wd)) else $error("counter write lost");
	a_pwm_start_level: assert property (@(posedge hclk) disable iff (!hresetn)
		ovf |=> raw_r == 4'hF) else $error("pwm start level wrong");

	// Counter, prescaler and overflow
	a_ovf_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_tcs && !ovf |=> !tcs_r[`TCS_OVF_BIT]) else $error("overflow flag not cleared by read");
	a_force_bit_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_tcs |-> hrdata[`TCS_FRL_BIT] == 1'b0) else $error("force bit read back set");
	a_run_counts: assert property (@(posedge hclk) disable iff (!hresetn)
		cnt_tick && !ovf && !cnt_wr && !force_rl |=> cnt_r == $past(cnt_r) + 8'h01) else $error("count step wrong");
	a_prescale_step: assert property (@(posedge hclk) disable iff (!hresetn)
		run && in_tick && !force_rl && !cnt_wr |=> pre_r == $past(pre_r) + 1'b1) else $error("prescaler step wrong");
	a_ext_tick: assert property (@(posedge hclk) disable iff (!hresetn)
		tcs_r[`TCS_EXT_BIT] && !ext_edge && !force_rl && !cnt_wr |=> $stable(pre_r) && $stable(cnt_r))
		else $error("count moved without external edge");

	// PWM outputs
	a_pwm_level: assert property (@(posedge hclk) disable iff (!hresetn)
		!ovf |=> raw_r == {cnt_r <= cmp_r[3], cnt_r <= cmp_r[2], cnt_r <= cmp_r[1], cnt_r <= cmp_r[0]})
		else $error("pwm level off compare");
	a_duty_to_cmp: assert property (@(posedge hclk) disable iff (!hresetn)
		ovf |=> cmp_r[3] == $past(duty_r[3])) else $error("compare not loaded at overflow");
	a_pol_immediate: assert property (@(posedge hclk) disable iff (!hresetn)
		$stable(raw_r) |-> (pwm_channel_out ^ $past(pwm_channel_out)) == (pwmctl_r.polarity ^ $past(pwmctl_r.polarity)))
		else $error("polarity change not immediate");
	a_oe_drive: assert property (@(posedge hclk) disable iff (!hresetn)
		pwm_pin_oe_n == ~pwmctl_r.out_en) else $error("pin enable mismatch");

	// Capture
	a_cap_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		cap_event(capture_input_pin[1], cap_d_r[1], capctl_r.sense[1]) && !capflag_r[1]
		|=> capflag_r[1] && capdata_r[1] == $past(cnt_r)) else $error("capture not taken");
	a_cap_read_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_cap[0] && capflag_r[0] |=> !capflag_r[0]) else $error("capture flag not cleared by read");
	a_cap_data_ro: assert property (@(posedge hclk) disable iff (!hresetn)
		!cap_event(capture_input_pin[0], cap_d_r[0], capctl_r.sense[0]) |=> $stable(capdata_r[0]))
		else $error("capture data changed without capture");
	a_cap_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		!capctl_r.irq_en[0] |-> !capture_irq[0]) else $error("capture irq not gated");

	// ************************************************************
	// Cover points
	// ************************************************************
	c_overflow: cover property (@(posedge hclk) disable iff (!hresetn) ovf);
	c_polarity: cover property (@(posedge hclk) disable iff (!hresetn) $changed(pwmctl_r.polarity));
	c_capture: cover property (@(posedge hclk) disable iff (!hresetn) capflag_r[1] && rd_cap[1]);
	c_force: cover property (@(posedge hclk) disable iff (!hresetn) force_rl);
	c_ext_clock: cover property (@(posedge hclk) disable iff (!hresetn) cnt_tick && tcs_r[7]);

endmodule : pwm_autoreload_timer

/* File: pwm_autoreload_timer_tb_top.sv */
// Self-checking testbench for the PWM auto-reload timer
`timescale 1ns/1ps
`include "pwm_reload_cfg.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin miscompares++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end

module pwm_autoreload_timer_tb_top;
	import pwm_reload_pkg::*;

	logic hclk, hresetn, hsel, hwrite, hready, ext_clk_in;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, capture_input_pin, capture_irq;
	logic [2:0] hsize;
	logic hreadyout, hresp, overflow_irq;
	logic [3:0] pwm_channel_out, pwm_pin_oe_n;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	int i, n, k;
	int duty_high[4] = '{20, 40, 30, 10};

	pwm_autoreload_timer i_pwm_autoreload_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_clk_in(ext_clk_in), .capture_input_pin(capture_input_pin),
		.pwm_channel_out(pwm_channel_out), .pwm_pin_oe_n(pwm_pin_oe_n), .overflow_irq(overflow_irq),
		.capture_irq(capture_irq));

	// One slave on the bus, so its ready is the bus ready
	assign hready = hreadyout;

	always #12.5 hclk = ~hclk;

	// ************************************
	// Bus tasks
	// ************************************
	task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h000000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h000000, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata[7:0];
	endtask : xfer

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] unused;
		xfer(idx, 1'b1, d, unused);
	endtask : wr

	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] ex, input string nm);
		logic [7:0] v;
		xfer(idx, 1'b0, 8'h00, v);
		`CHK(nm, ex, v)
	endtask : rd_chk

	// Counts whole cycles until the overflow request shows, bounded
	task automatic wait_ovf(output int cnt);
		cnt = 0;
		do begin
			@(posedge hclk);
			#1;
			cnt++;
		end while (overflow_irq !== 1'b1 && cnt < 2000);
	endtask : wait_ovf

	task automatic count_high(input int ch, output int cnt);
		cnt = 0;
		repeat (40) begin
			@(posedge hclk);
			#1;
			if (pwm_channel_out[ch] === 1'b1)
				cnt++;
		end
	endtask : count_high

	task automatic ext_pulse();
		@(posedge hclk);
		ext_clk_in <= 1'b1;
		repeat (2) @(posedge hclk);
		ext_clk_in <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask : ext_pulse

	task automatic final_report();
		if (miscompares == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	// Hang guard, well above the longest prescaler sweep
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			final_report();
		end
	end

	// ************************************
	// Test sequence
	// ************************************
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		ext_clk_in = 1'b0;
		capture_input_pin = 2'b10;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		for (i = 0; i < 11; i++)
			rd_chk(8'(`IDX_DUTY3 + i), 8'h00, "reset value");
		`CHK("pin enables", 4'hF, pwm_pin_oe_n)
		rd_chk(8'h3C, 8'h00, "unmapped");
		`CHK("response", 1'b0, hresp)
		`CHK("ready", 1'b1, hreadyout)
		wr(`IDX_CAP1, 8'hA5);
		rd_chk(`IDX_CAP1, 8'h00, "capture data write");
		wr(`IDX_CCS, 8'hFF);
		rd_chk(`IDX_CCS, 8'h3C, "capture ctl");
		wr(`IDX_RELOAD, 8'hF0);
		wr(`IDX_CNT, 8'h33);
		rd_chk(`IDX_CNT, 8'h33, "held counter");
		wr(`IDX_TCS, 8'h04);
		rd_chk(`IDX_TCS, 8'h00, "force bit");
		rd_chk(`IDX_CNT, 8'hF0, "reloaded counter");
		// Four counts per period, stretched by each prescale setting
		wr(`IDX_RELOAD, 8'hFC);
		for (n = 0; n < 8; n++) begin
			wr(`IDX_TCS, 8'h00);
			// The stop write clears the prescale field; the last overflow flag survives it
			rd_chk(`IDX_TCS, (n == 0) ? 8'h00 : 8'h01, "stopped status");
			wr(`IDX_CNT, 8'hFC);
			wr(`IDX_TCS, {1'b0, 3'(n), 4'hA});
			wait_ovf(k);
			`CHK("overflow period", 4 << n, k)
		end
		rd_chk(`IDX_TCS, 8'h7B, "flag set");
		rd_chk(`IDX_TCS, 8'h7A, "flag cleared");
		`CHK("irq after clear", 1'b0, overflow_irq)
		wr(`IDX_TCS, 8'h08);
		repeat (8) @(posedge hclk);
		`CHK("masked irq", 1'b0, overflow_irq)
		rd_chk(`IDX_TCS, 8'h09, "flag without enable");
		// External count source
		wr(`IDX_TCS, 8'h00);
		wr(`IDX_CNT, 8'hFC);
		rd_chk(`IDX_TCS, 8'h01, "status before ext");
		wr(`IDX_TCS, 8'h8A);
		repeat (3) ext_pulse();
		`CHK("ext three events", 1'b0, overflow_irq)
		ext_pulse();
		`CHK("ext four events", 1'b1, overflow_irq)
		// PWM waveforms with period four
		wr(`IDX_TCS, 8'h00);
		wr(`IDX_DUTY0, 8'hFD);
		wr(`IDX_DUTY1, 8'hFF);
		wr(`IDX_DUTY2, 8'hFE);
		wr(`IDX_DUTY3, 8'hFC);
		wr(`IDX_PWMCTL, 8'h50);
		@(posedge hclk);
		`CHK("pin enables", 4'hA, pwm_pin_oe_n)
		wr(`IDX_TCS, 8'h08);
		repeat (12) @(posedge hclk);
		for (i = 0; i < 4; i++) begin
			count_high(i, k);
			`CHK("duty high count", duty_high[i], k)
		end
		wr(`IDX_PWMCTL, 8'h5F);
		for (i = 0; i < 4; i++) begin
			count_high(i, k);
			`CHK("inverted high count", 40 - duty_high[i], k)
		end
		// Captures on a frozen counter
		wr(`IDX_TCS, 8'h00);
		wr(`IDX_CNT, 8'h5A);
		wr(`IDX_CCS, 8'h1C);
		@(posedge hclk);
		capture_input_pin <= 2'b01;
		repeat (3) @(posedge hclk);
		`CHK("capture irq", 2'b11, capture_irq)
		rd_chk(`IDX_CCS, 8'h1F, "capture flags");
		rd_chk(`IDX_CAP1, 8'h5A, "capture one");
		@(posedge hclk);
		`CHK("capture irq after read", 2'b10, capture_irq)
		capture_input_pin <= 2'b10;
		rd_chk(`IDX_CAP2, 8'h5A, "capture two");
		rd_chk(`IDX_CCS, 8'h1C, "wrong edge");
		wr(`IDX_CNT, 8'h77);
		wr(`IDX_CCS, 8'h30);
		capture_input_pin <= 2'b00;
		repeat (3) @(posedge hclk);
		capture_input_pin <= 2'b11;
		repeat (3) @(posedge hclk);
		`CHK("disabled capture irq", 2'b00, capture_irq)
		rd_chk(`IDX_CCS, 8'h33, "rising captures");
		rd_chk(`IDX_CAP1, 8'h77, "new capture");
		final_report();
	end
endmodule : pwm_autoreload_timer_tb_top

/* File: pwm_reload_cfg.svh */
// Register offsets, field positions and reset values of the PWM auto-reload timer
`ifndef PWM_RELOAD_CFG_SVH
`define PWM_RELOAD_CFG_SVH

// Printed offsets are register indices; byte address is index times four
`define IDX_DUTY3 8'h31
`define IDX_DUTY2 8'h32
`define IDX_DUTY1 8'h33
`define IDX_DUTY0 8'h34
`define IDX_PWMCTL 8'h35
`define IDX_TCS 8'h36
`define IDX_CNT 8'h37
`define IDX_RELOAD 8'h38
`define IDX_CCS 8'h39
`define IDX_CAP1 8'h3A
`define IDX_CAP2 8'h3B

`define TCS_EXT_BIT 7
`define TCS_PRE_HI 6
`define TCS_PRE_LO 4
`define TCS_RUN_BIT 3
`define TCS_FRL_BIT 2
`define TCS_OIE_BIT 1
`define TCS_OVF_BIT 0

`define REG_RESET 8'h00
`define CNT_TOP 8'hFF
`define PRE_WIDTH 7

`endif

/* File: pwm_reload_pkg.sv */
// Types shared by the PWM auto-reload timer
package pwm_reload_pkg;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DATA = 2'b10
	} bus_state_e;

	typedef struct packed {
		logic [7:0] index;
		logic write;
		logic read;
	} bus_req_s;

	typedef struct packed {
		logic [3:0] out_en;
		logic [3:0] polarity;
	} pwm_ctl_s;

	typedef struct packed {
		logic [1:0] sense;
		logic [1:0] irq_en;
	} cap_ctl_s;

endpackage : pwm_reload_pkg
